//--- src/ssap_map.svh
// Constants of the stereo serial audio port: rates, word size, reset values.
// Assumes the core clock is the reference clock of the bit clock divider.
`ifndef SSAP_MAP_SVH
`define SSAP_MAP_SVH

// Reference clock rate feeding the fractional divider, in Hz
`define SSAP_REF_HZ 100000000
// Master frame rate, in Hz
`define SSAP_FS_HZ 48000
// Master bit clocks per frame, the two selectable lengths
`define SSAP_BITS_SHORT 32
`define SSAP_BITS_LONG 50
// Highest bit clock accepted from the far party in slave mode, in Hz
`define SSAP_SLAVE_MAX_HZ 3072000
// Bits in one channel word
`define SSAP_WORD_BITS 16
// Receive bit counter value meaning idle
`define SSAP_RX_IDLE 5'h10
// Reset level of bit clock and word select
`define SSAP_SCK_RST 1'b0
`define SSAP_WS_RST 1'b0

`endif

//--- src/ssap_pkg.sv
// Types shared by the stereo serial audio port.
// Assumes ssap_map.svh supplies the numeric constants.
`include "ssap_map.svh"

package ssap_pkg;
    typedef logic [`SSAP_WORD_BITS-1:0] ssap_word_t;
    typedef logic [27:0] ssap_acc_t;
    typedef enum logic [0:0] {
        SSAP_SLAVE = 1'b0,
        SSAP_MASTER = 1'b1
    } ssap_mode_e;
endpackage

//--- src/ssap_top.sv
// Stereo serial audio port core and the two-port top.
// Assumes clk is the reference clock; pins arrive asynchronous to it.
//
// Notes on behaviour
// - Two independent ports, each master or slave.
// - Master drives clock and select; slave receives.
// - Serial data output is always driven.
// - Each channel word is sixteen bits.
// - Left word MSB leads the frame.
// - MSB one bit clock after select change.
// - Left while select low, right while high.
// - Data changes only on falling clock edges.
// - Master frames 48 kHz, 32 or 50 bits.
// - Master bit clock from N over M divider.
// - Slave takes any clock up to 3.072 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "ssap_map.svh"

////////////////////////////////////////////////////////////////////////////
module ssap_port
    import ssap_pkg::*;
(
    input wire logic clk, // Reference clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire ssap_mode_e mode, // Master or slave
    input wire logic frame_long, // Master frame of 50 bits when high
    input wire logic sck_i, // Bit clock pin level
    output logic sck_o, // Bit clock driven in master mode
    output logic sck_oe, // Bit clock drive enable
    input wire logic ws_i, // Word select pin level
    output logic ws_o, // Word select driven in master mode
    output logic ws_oe, // Word select drive enable
    output logic sdo, // Serial data out, always driven
    input wire logic sdi, // Serial data in pin
    input wire ssap_word_t tx_left, // Left word to send
    input wire ssap_word_t tx_right, // Right word to send
    output logic tx_taken, // Pulse: a tx word was loaded
    output ssap_word_t rx_left, // Last left word received
    output ssap_word_t rx_right, // Last right word received
    output logic rx_valid // Pulse: a rx word was stored
);
    localparam ssap_acc_t REF_M = 28'(`SSAP_REF_HZ);
    localparam ssap_acc_t INC_SHORT =
        28'(2 * `SSAP_FS_HZ * `SSAP_BITS_SHORT);
    localparam ssap_acc_t INC_LONG =
        28'(2 * `SSAP_FS_HZ * `SSAP_BITS_LONG);
    localparam int SLAVE_HALF_NS = 1000000000 / (2 * `SSAP_SLAVE_MAX_HZ);

    // Bit clocks in one channel half of a master frame
    function automatic logic [5:0] half_bits(input logic long_sel);
        half_bits = long_sel ? 6'(`SSAP_BITS_LONG / 2)
                             : 6'(`SSAP_BITS_SHORT / 2);
    endfunction

    logic [2:0] sck_s_q;
    logic [2:0] sck_s_d;
    logic [1:0] ws_s_q;
    logic [1:0] ws_s_d;
    logic [1:0] sdi_s_q;
    logic [1:0] sdi_s_d;
    ssap_acc_t acc_q;
    ssap_acc_t acc_d;
    ssap_acc_t acc_sum;
    logic sck_q;
    logic sck_d;
    logic ws_q;
    logic ws_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic wsr_q;
    logic wsr_d;
    logic wsf_q;
    logic wsf_d;
    ssap_word_t tx_sh_q;
    ssap_word_t tx_sh_d;
    logic sdo_q;
    logic sdo_d;
    logic tx_taken_q;
    logic tx_taken_d;
    ssap_word_t rx_sh_q;
    ssap_word_t rx_sh_d;
    logic [4:0] rx_cnt_q;
    logic [4:0] rx_cnt_d;
    logic rx_ch_q;
    logic rx_ch_d;
    ssap_word_t rx_l_q;
    ssap_word_t rx_l_d;
    ssap_word_t rx_r_q;
    ssap_word_t rx_r_d;
    logic rx_valid_q;
    logic rx_valid_d;
    logic tick;
    logic rise;
    logic fall;
    logic ws_line;
    logic sdi_line;
    ssap_word_t word;

    // Next-state logic of the whole port
    always_comb begin
        // Pin synchronisers; first stage feeds only the second
        sck_s_d = {sck_s_q[1:0], sck_i};
        ws_s_d = {ws_s_q[0], ws_i};
        sdi_s_d = {sdi_s_q[0], sdi};
        // Divider steps by N each clock and wraps at M
        acc_sum = acc_q + (frame_long ? INC_LONG : INC_SHORT);
        tick = 1'b0;
        acc_d = '0;
        sck_d = sck_q;
        if (mode == SSAP_MASTER) begin
            if (acc_sum >= REF_M) begin
                acc_d = acc_sum - REF_M;
                tick = 1'b1;
            end else begin
                acc_d = acc_sum;
            end
            if (tick) begin
                sck_d = ~sck_q;
            end
        end
        // Edge events from our own clock or the synchronised pin
        if (mode == SSAP_MASTER) begin
            rise = tick & ~sck_q;
            fall = tick & sck_q;
            ws_line = ws_q;
        end else begin
            rise = sck_s_q[1] & ~sck_s_q[2];
            fall = ~sck_s_q[1] & sck_s_q[2];
            ws_line = ws_s_q[1];
        end
        sdi_line = sdi_s_q[1];
        // Master select toggles on a falling edge each half frame
        ws_d = (mode == SSAP_MASTER) ? ws_q : `SSAP_WS_RST;
        cnt_d = (mode == SSAP_MASTER) ? cnt_q : 6'h00;
        if (mode == SSAP_MASTER && fall) begin
            if (cnt_q >= half_bits(frame_long) - 6'h01) begin
                cnt_d = 6'h00;
                ws_d = ~ws_q;
            end else begin
                cnt_d = cnt_q + 6'h01;
            end
        end
        // Select is sampled on rises, where it is settled
        wsr_d = rise ? ws_line : wsr_q;
        // Receive: shift on rises, publish after sixteen bits
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        rx_ch_d = rx_ch_q;
        rx_l_d = rx_l_q;
        rx_r_d = rx_r_q;
        rx_valid_d = 1'b0;
        if (rise) begin
            if (rx_cnt_q < `SSAP_RX_IDLE) begin
                rx_sh_d = {rx_sh_q[14:0], sdi_line};
                rx_cnt_d = rx_cnt_q + 5'h01;
                if (rx_cnt_q == `SSAP_RX_IDLE - 5'h01) begin
                    rx_valid_d = 1'b1;
                    if (rx_ch_q) begin
                        rx_r_d = {rx_sh_q[14:0], sdi_line};
                    end else begin
                        rx_l_d = {rx_sh_q[14:0], sdi_line};
                    end
                end
            end
            // The LSB may share this rise with a select edge
            if (ws_line != wsr_q) begin
                rx_cnt_d = 5'h00;
                rx_ch_d = ws_line;
            end
        end
        // Transmit: every change is made on a falling edge
        wsf_d = wsf_q;
        tx_sh_d = tx_sh_q;
        sdo_d = sdo_q;
        tx_taken_d = 1'b0;
        word = wsr_q ? tx_right : tx_left;
        if (fall) begin
            wsf_d = wsr_q;
            if (wsr_q != wsf_q) begin
                // Edge seen one bit ago, so the MSB goes now
                sdo_d = word[15];
                tx_sh_d = {word[14:0], 1'b0};
                tx_taken_d = 1'b1;
            end else begin
                sdo_d = tx_sh_q[15];
                tx_sh_d = {tx_sh_q[14:0], 1'b0};
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_s_q <= 3'h0;
            ws_s_q <= 2'h0;
            sdi_s_q <= 2'h0;
            acc_q <= '0;
            sck_q <= `SSAP_SCK_RST;
            ws_q <= `SSAP_WS_RST;
            cnt_q <= 6'h00;
            wsr_q <= `SSAP_WS_RST;
            wsf_q <= `SSAP_WS_RST;
            tx_sh_q <= 16'h0000;
            sdo_q <= 1'b0;
            tx_taken_q <= 1'b0;
            rx_sh_q <= 16'h0000;
            rx_cnt_q <= `SSAP_RX_IDLE;
            rx_ch_q <= 1'b0;
            rx_l_q <= 16'h0000;
            rx_r_q <= 16'h0000;
            rx_valid_q <= 1'b0;
        end else begin
            sck_s_q <= sck_s_d;
            ws_s_q <= ws_s_d;
            sdi_s_q <= sdi_s_d;
            acc_q <= acc_d;
            sck_q <= sck_d;
            ws_q <= ws_d;
            cnt_q <= cnt_d;
            wsr_q <= wsr_d;
            wsf_q <= wsf_d;
            tx_sh_q <= tx_sh_d;
            sdo_q <= sdo_d;
            tx_taken_q <= tx_taken_d;
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
            rx_ch_q <= rx_ch_d;
            rx_l_q <= rx_l_d;
            rx_r_q <= rx_r_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    // Pin drive: clock and select only as master, data always
    assign sck_o = sck_q;
    assign sck_oe = (mode == SSAP_MASTER);
    assign ws_o = ws_q;
    assign ws_oe = (mode == SSAP_MASTER);
    assign sdo = sdo_q;
    assign tx_taken = tx_taken_q;
    assign rx_left = rx_l_q;
    assign rx_right = rx_r_q;
    assign rx_valid = rx_valid_q;
endmodule // ssap_port

////////////////////////////////////////////////////////////////////////////
module ssap_top
    import ssap_pkg::*;
(
    input wire logic clk, // Reference clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [1:0] master, // Per port: high for master mode
    input wire logic [1:0] frame_long, // Per port: 50-bit master frame
    input wire logic [1:0] sck_i, // Bit clock pin levels
    output logic [1:0] sck_o, // Bit clock outputs
    output logic [1:0] sck_oe, // Bit clock drive enables
    input wire logic [1:0] ws_i, // Word select pin levels
    output logic [1:0] ws_o, // Word select outputs
    output logic [1:0] ws_oe, // Word select drive enables
    output logic [1:0] sdo, // Serial data outputs
    input wire logic [1:0] sdi, // Serial data inputs
    input wire logic [1:0][15:0] tx_left, // Left words to send
    input wire logic [1:0][15:0] tx_right, // Right words to send
    output logic [1:0] tx_taken, // Word loaded pulses
    output logic [1:0][15:0] rx_left, // Received left words
    output logic [1:0][15:0] rx_right, // Received right words
    output logic [1:0] rx_valid // Word received pulses
);
    // Two ports share nothing but clock and reset
    for (genvar i = 0; i < 2; i++) begin : g_port
        ssap_port u_port (
            .clk(clk),
            .rst_n(rst_n),
            .mode(ssap_mode_e'(master[i])),
            .frame_long(frame_long[i]),
            .sck_i(sck_i[i]),
            .sck_o(sck_o[i]),
            .sck_oe(sck_oe[i]),
            .ws_i(ws_i[i]),
            .ws_o(ws_o[i]),
            .ws_oe(ws_oe[i]),
            .sdo(sdo[i]),
            .sdi(sdi[i]),
            .tx_left(tx_left[i]),
            .tx_right(tx_right[i]),
            .tx_taken(tx_taken[i]),
            .rx_left(rx_left[i]),
            .rx_right(rx_right[i]),
            .rx_valid(rx_valid[i])
        );
    end
endmodule // ssap_top
`default_nettype wire

//--- dv/ssap_top_asserts.sv
// Checker on the top: port 0 runs as master, port 1 as slave.
// Assumes it is bound to ssap_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ssap_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic [1:0] master, // Mode
    input wire logic [1:0] frame_long, // 50-bit frame
    input wire logic [1:0] sck_i, // Pin clock
    input wire logic [1:0] sck_o, // Made clock
    input wire logic [1:0] ws_i, // Pin select
    input wire logic [1:0] ws_o, // Made select
    input wire logic [1:0] sdo, // Data out
    input wire logic [1:0][15:0] tx_left, // Left to send
    input wire logic [1:0][15:0] tx_right, // Right to send
    input wire logic [1:0] tx_taken, // Load pulse
    input wire logic [1:0][15:0] rx_left, // Left heard
    input wire logic [1:0] rx_valid // Store pulse
);
    logic [5:0] hc_q; // Clocks since the bit clock moved
    logic [4:0] fc_q; // Falls since the select moved
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Counters; the fractional divider jitters one clock, hence ranges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hc_q <= 6'h00;
            fc_q <= 5'h00;
        end else begin
            hc_q <= $changed(sck_o[0]) ? 6'h01 : hc_q + 6'h01;
            if ($changed(ws_o[0])) begin
                fc_q <= 5'h00;
            end else if ($fell(sck_o[0])) begin
                fc_q <= fc_q + 5'h01;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Link timing of the master port and the slave port
    // The halves of the long frame are 20 or 21 clocks, of the short one
    // 32 or 33; one wide range would let the wrong rate through
    sck_half_a: assert property ($changed(sck_o[0]) |->
        (frame_long[0] ? (hc_q inside {[20:21]})
                       : (hc_q inside {[32:33]})))
        else $error("bit clock half out of range");
    ws_bits_a: assert property ($changed(ws_o[0]) |->
        fc_q == (frame_long[0] ? 5'h18 : 5'h0F)) else $error("bad half");
    sdo_fall_a: assert property (master[0] && $changed(sdo[0]) |->
        $fell(sck_o[0])) else $error("data moved off a falling edge");
    ws_fall_a: assert property ($changed(ws_o[0]) |-> $fell(sck_o[0]))
        else $error("select moved off a falling edge");
    msb_first_a: assert property (tx_taken[0] |-> sdo[0] ==
        (ws_o[0] ? tx_right[0][15] : tx_left[0][15])) else $error("bad msb");
    msb_delay_a: assert property ($changed(ws_o[0]) |=>
        (!tx_taken[0])[*8] ##[30:60] tx_taken[0]) else $error("msb late");
    rx_update_a: assert property ($changed(rx_left[1]) |-> rx_valid[1])
        else $error("word stored without pulse");
    slave_sdo_a: assert property (!master[1] && $changed(sdo[1]) |->
        !$past(sck_i[1], 2)) else $error("slave data moved on a high clock");
    // Slave loads pick the word by the select level on the pin
    slave_msb_a: assert property (tx_taken[1] |-> sdo[1] ==
        (ws_i[1] ? tx_right[1][15] : tx_left[1][15]))
        else $error("bad slave msb");
    rx_store_a: assert property ($changed(rx_left[0]) |-> rx_valid[0])
        else $error("master word stored without pulse");
endmodule // ssap_chk
bind ssap_top ssap_chk u_chk (.clk, .rst_n, .master, .frame_long, .sck_i,
    .sck_o, .ws_i, .ws_o, .sdo, .tx_left, .tx_right, .tx_taken, .rx_left,
    .rx_valid);
`default_nettype wire

//--- dv/ssap_codec.sv
// Far-side codec: makes clock, select and data for a slave port, and
// listens to one line. Assumes a timebase unrelated to the core clock.
`timescale 1ns/1ps
`default_nettype none
module ssap_codec #(
    parameter int HALF_NS = 210 // Half bit period, below the slave limit
) (
    input wire logic run, // Make frames while high
    input wire logic [15:0] tx_l, // Left word sent
    input wire logic [15:0] tx_r, // Right word sent
    output logic sck, // Made bit clock
    output logic ws, // Made select
    output logic sd, // Made data
    input wire logic sck_in, // Heard clock
    input wire logic ws_in, // Heard select
    input wire logic sd_in, // Heard data
    output logic [15:0] rx_l, // Last left heard
    output logic [15:0] rx_r // Last right heard
);
    logic [15:0] sh;
    logic wp = 1'b0;
    logic hw;
    int n = 99;
    ////////////////////////////////////////////////////////////////////////
    // Frames of 32 bits; clock stands low and data toggles when idle
    initial begin
        sck = 1'b0;
        ws = 1'b0;
        sd = 1'b0;
        forever begin
            if (!run) begin
                #HALF_NS;
                sck = 1'b0;
                sd = ~sd;
            end else begin
                for (int b = 0; b < 32; b++) begin
                    sck = 1'b0;
                    ws = b[4];
                    sd = (b % 16 == 0) ? (b < 16 ? tx_r[0] : tx_l[0]) :
                        (b < 16 ? tx_l[16 - b % 16] : tx_r[16 - b % 16]);
                    #HALF_NS;
                    sck = 1'b1;
                    #HALF_NS;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Receiver samples on rising edges; LSB may share the select edge
    always @(posedge sck_in) begin
        if (n > 0 && n <= 16) sh = {sh[14:0], sd_in};
        if (n == 16 && hw) rx_r = sh;
        if (n == 16 && !hw) rx_l = sh;
        if (ws_in != wp) hw = ws_in;
        n = (ws_in != wp) ? 1 : n + 1;
        wp = ws_in;
    end
endmodule // ssap_codec
`default_nettype wire

//--- dv/stereo_serial_audio_port_tb.sv
// Bench: port 0 master with looped-back data, port 1 slave to a codec.
// Assumes the codec model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module stereo_serial_audio_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] master = 2'h1;
    logic [1:0] frame_long = 2'h0;
    logic [1:0][15:0] tx_left = {16'h9E31, 16'h0000};
    logic [1:0][15:0] tx_right = {16'h4C7A, 16'h0000};
    logic run_b = 1'b0;
    logic [15:0] bl = 16'hC3D1;
    logic [15:0] br = 16'h0F5A;
    logic [1:0] sck_i, sck_o, sck_oe, ws_i, ws_o, ws_oe, sdo, sdi;
    logic [1:0] tx_taken, rx_valid;
    logic [1:0][15:0] rx_left, rx_right;
    logic a_sck, a_ws, a_sd, b_sck, b_ws, b_sd;
    logic [15:0] a_l, a_r, b_l, b_r;
    int err_count = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, and pin levels: whoever is master drives the shared wire
    always #5 clk = ~clk;
    assign sck_i = {sck_oe[1] ? sck_o[1] : b_sck, sck_oe[0] ? sck_o[0] : a_sck};
    assign ws_i = {ws_oe[1] ? ws_o[1] : b_ws, ws_oe[0] ? ws_o[0] : a_ws};
    assign sdi = {b_sd, sdo[0]}; // Port 0 hears its own output
    ssap_top u_dut (.clk, .rst_n, .master, .frame_long, .sck_i, .sck_o,
        .sck_oe, .ws_i, .ws_o, .ws_oe, .sdo, .sdi, .tx_left, .tx_right,
        .tx_taken, .rx_left, .rx_right, .rx_valid);
    ssap_codec u_a (.run(1'b0), .tx_l(bl), .tx_r(br), .sck(a_sck),
        .ws(a_ws), .sd(a_sd), .sck_in(sck_o[0]), .ws_in(ws_o[0]),
        .sd_in(sdo[0]), .rx_l(a_l), .rx_r(a_r));
    ssap_codec u_b (.run(run_b), .tx_l(bl), .tx_r(br), .sck(b_sck),
        .ws(b_ws), .sd(b_sd), .sck_in(b_sck), .ws_in(b_ws),
        .sd_in(sdo[1]), .rx_l(b_l), .rx_r(b_r));
    ////////////////////////////////////////////////////////////////////////
    // Compare and closing
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Master port: reset mid-run, stream, then time one select half
    task automatic master_run(input logic fl, input logic [15:0] l, r);
        int n;
        int k;
        logic p;
        logic s;
        @(negedge clk);
        rst_n = 1'b0;
        frame_long[0] = fl;
        tx_left[0] = l;
        tx_right[0] = r;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (8000) @(negedge clk);
        cmp(a_l, l);
        cmp(a_r, r);
        cmp(rx_left[0], l);
        cmp(rx_right[0], r);
        n = 0;
        p = ws_o[0];
        while (ws_o[0] === p && n < 3000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        k = 0;
        p = ws_o[0];
        s = sck_o[0];
        while (ws_o[0] === p && n < 3000) begin
            @(negedge clk);
            n++;
            k += int'(!s && sck_o[0]);
            s = sck_o[0];
        end
        cmp(16'(k), fl ? 16'h0019 : 16'h0010);
        cmp(16'(n > 1040 && n < 1043), 16'h0001);
    endtask
    // Slave port fed by the codec while port 0 keeps running as master
    task automatic slave_run;
        run_b = 1'b1;
        repeat (12000) @(negedge clk);
        cmp(rx_left[1], bl);
        cmp(rx_right[1], br);
        cmp(b_l, tx_left[1]);
        cmp(b_r, tx_right[1]);
        cmp({14'h0000, sck_oe[1], ws_oe[1]}, 16'h0000);
        cmp({14'h0000, sck_oe[0], ws_oe[0]}, 16'h0003);
        cmp(a_l, tx_left[0]);
        run_b = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence, and a watchdog at about twice its length
    initial begin
        master_run(1'b0, 16'h8001, 16'h7FFE);
        master_run(1'b1, 16'hA5C3, 16'h5A3C);
        slave_run();
        complete_run();
    end
    initial begin
        #600000;
        err_count++;
        complete_run();
    end
endmodule // stereo_serial_audio_port_tb
`default_nettype wire
